// [verilog/hsc_quad_front.sv]
// Quadrant mode control, sample requantization and lag-zero correlation
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/100ps
`include "hsc_map.svh"

module hsc_quad_front #(
  parameter int QUADS = 4,
  parameter int LANES = `HSC_DEMUX,
  parameter int ANTS = 64,
  parameter int ACC_W = 32
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [QUADS-1:0] smp_valid,
  input wire logic [QUADS-1:0][LANES-1:0][2:0] smp_x,
  input wire logic [QUADS-1:0][LANES-1:0][2:0] smp_y,
  output logic [QUADS-1:0] wb_valid,
  output logic [QUADS-1:0][LANES-1:0][1:0] wb_x,
  output logic [QUADS-1:0][LANES-1:0][1:0] wb_y,
  output logic [QUADS-1:0] fb_valid,
  output logic [QUADS-1:0][LANES-1:0][2:0] fb_x,
  output logic [QUADS-1:0][LANES-1:0][2:0] fb_y,
  output hsc_pkg::hsc_cfg_type [QUADS-1:0] fb_cfg,
  output hsc_pkg::hsc_win_type [QUADS-1:0][3:0] fb_win,
  output logic irq
);

  // ---------------------------------------------
  // Rate figures
  // ---------------------------------------------
  // Lane count times the correlation clock equals the sample rate
  // The datapath takes one whole word of LANES samples per clk cycle,
  // so the lane split is fixed here rather than by a faster clock
  localparam longint SMP_HZ = `HSC_SMP_HZ;
  localparam longint LANE_HZ = SMP_HZ / LANES;
  // Antenna count sets how many streams share one quadrant
  localparam int ANT_MAX = ANTS;

  // ---------------------------------------------
  // Decode functions
  // ---------------------------------------------
  // Two-bit level to odd weight -3, -1, +1, +3
  // Odd weights keep the product table symmetric about zero
  function automatic logic signed [2:0] lvl(input logic [1:0] c);
    lvl = 3'(signed'({1'b0, c, 1'b0}) - 4'sh3);
  endfunction

  // Lag-zero product summed over all lanes of one word
  // Worst case is 32 lanes of 3 times 3, well inside twelve signed bits
  function automatic logic signed [11:0] lag0(
    input logic [LANES-1:0][1:0] a,
    input logic [LANES-1:0][1:0] b
  );
    logic signed [11:0] s;
    s = '0;
    for (int i = 0; i < LANES; i++) begin
      s = s + 12'(lvl(a[i]) * lvl(b[i]));
    end
    return s;
  endfunction

  // Sub-bands per window for a code
  // Codes above the largest legal one give zero and are refused anyway
  function automatic logic [5:0] nsub(input logic [2:0] code);
    return `HSC_SUB_NUM >> code;
  endfunction

  // Whole staged setup passes every limit
  // Checks run on the staged copy, so a bad setup never reaches a quadrant
  // Window limits apply only to the windows in use in narrowband mode
  function automatic logic cfg_ok(
    input hsc_pkg::hsc_cfg_type c,
    input hsc_pkg::hsc_win_type [3:0] w
  );
    logic ok;
    logic [5:0] top;
    ok = (c.sb_code <= `HSC_SB_MAX) && (c.avg_code <= `HSC_AVG_MAX);
    ok = ok && (c.nwin != 3'h0) && (c.nwin <= `HSC_WIN_MAX);
    for (int k = 0; k < 4; k++) begin
      top = {1'b0, w[k].start} + nsub(c.sb_code);
      // Last sub-band must end at the band edge at most
      if (c.narrow && (3'(k) < c.nwin) && (top > `HSC_SUB_NUM)) begin
        ok = 1'b0;
      end
      // A tuning offset pushes the top edge up, so room must remain
      if (c.narrow && (3'(k) < c.nwin) && (w[k].tune != 11'h000)
          && (top == `HSC_SUB_NUM)) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // Output channel count of one window
  // The base count already leaves out the overlapped sub-band edges
  function automatic logic [12:0] chans(input hsc_pkg::hsc_cfg_type c);
    logic [12:0] n;
    n = c.narrow ? `HSC_NB_CHAN : `HSC_WB_CHAN;
    n = c.pol_full ? (n >> 2) : (n >> 1);
    // One averaging factor per baseband keeps spacing equal
    if (c.narrow) begin
      n = n >> c.avg_code;
    end
    return n;
  endfunction

  // Window words sit between the setup word and the commit word,
  // word aligned; the last of them shares the upper address nibble
  function automatic logic win_hit(input logic [7:0] a);
    return (a >= `HSC_A_WIN0) && (a < `HSC_A_COMMIT) && (a[1:0] == 2'h0);
  endfunction

  // Window slot of a window word offset
  function automatic logic [1:0] win_slot(input logic [7:0] a);
    logic [7:0] d;
    d = a - `HSC_A_WIN0;
    return d[3:2];
  endfunction

  // ---------------------------------------------
  // Register state
  // ---------------------------------------------
  hsc_pkg::hsc_cfg_type stage_r; // Staged setup
  hsc_pkg::hsc_win_type [3:0] swin_r; // Staged windows
  hsc_pkg::hsc_cfg_type [QUADS-1:0] cfg_r; // Applied setups
  hsc_pkg::hsc_win_type [QUADS-1:0][3:0] win_r; // Applied windows
  logic [`HSC_ST_W-1:0] sts_r; // Sticky events
  // Next status, set beats clear
  logic [`HSC_ST_W-1:0] sts_nxt;
  logic [`HSC_ST_W-1:0] en_r; // Interrupt enables
  // Sums are cleared on every applied commit of their quadrant
  logic signed [ACC_W-1:0] acc_r [QUADS][3]; // Auto x, auto y, cross
  // Outcome survives until the next commit
  hsc_pkg::hsc_commit_type cmt_r; // Last commit outcome
  // Read mux output, registered below
  logic [31:0] rd_val;

  // ---------------------------------------------
  // Write decode
  // ---------------------------------------------
  // Each strobe is decoded once into plain enables
  wire wr_stage = reg_wr && (reg_addr == `HSC_A_STAGE);
  wire wr_commit = reg_wr && (reg_addr == `HSC_A_COMMIT);
  wire wr_clear = reg_wr && (reg_addr == `HSC_A_CLEAR);
  wire wr_enable = reg_wr && (reg_addr == `HSC_A_ENABLE);
  // Window decode is shared by the write and read paths
  wire win_sel = win_hit(reg_addr);
  wire [1:0] win_idx = win_slot(reg_addr);
  // Quadrant number rides in the commit write data
  wire [1:0] cq = reg_wdata[1:0];
  wire cq_ok = 32'(cq) < QUADS;
  wire stage_ok = cfg_ok(stage_r, swin_r);
  // Every commit ends in exactly one of apply or reject
  wire do_apply = wr_commit && cq_ok && stage_ok;
  wire do_reject = wr_commit && !(cq_ok && stage_ok);
  wire [`HSC_ST_W-1:0] ev = {do_apply, do_reject};

  // Events set after the clear so a same-cycle event survives
  // Software may therefore see a bit stay set after clearing it
  assign sts_nxt = (sts_r & ~(wr_clear ? reg_wdata[`HSC_ST_W-1:0] : '0)) | ev;

  // ---------------------------------------------
  // Staging registers
  // ---------------------------------------------
  // Software builds a setup here; nothing takes effect until commit
  // A half-written setup can never reach a running quadrant
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // Wideband, two products, one window
      stage_r <= `HSC_RST_CFG;
      swin_r <= '0;
    end else if (wr_stage) begin
      stage_r <= reg_wdata[`HSC_STAGE_W-1:0];
    end else if (reg_wr && win_sel) begin
      // One of the four window words
      swin_r[win_idx] <= reg_wdata[`HSC_WIN_W-1:0];
    end
  end

  // ---------------------------------------------
  // Status, enable and interrupt
  // ---------------------------------------------
  // Interrupt level is a flop fed by the next status
  // Feeding it the next value saves a cycle and keeps irq a flop output
  // An enable written together with an event takes the new enable
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sts_r <= '0;
      en_r <= '0;
      irq <= 1'b0;
      cmt_r <= hsc_pkg::HSC_IDLE;
    end else begin
      sts_r <= sts_nxt;
      irq <= |(sts_nxt & (wr_enable ? reg_wdata[`HSC_ST_W-1:0] : en_r));
      if (wr_enable) begin
        en_r <= reg_wdata[`HSC_ST_W-1:0];
      end
      // Remember the outcome for readback
      // Without a commit the last outcome is kept
      case ({do_apply, do_reject})
        2'b10: cmt_r <= hsc_pkg::HSC_APPLY;
        2'b01: cmt_r <= hsc_pkg::HSC_REJECT;
        default: cmt_r <= cmt_r;
      endcase
    end
  end

  // ---------------------------------------------
  // Per-quadrant configuration and datapath
  // ---------------------------------------------
  // Quadrant index of the generate loop
  genvar q;
  generate
    for (q = 0; q < QUADS; q++) begin : g_quad
      // One copy per quadrant, each taking its own mode on commit
      // Quadrant-local view of the two streams
      wire narrow = cfg_r[q].narrow;
      wire [LANES-1:0][1:0] tx;
      wire [LANES-1:0][1:0] ty;
      // Commit addressed to this quadrant
      wire hit = do_apply && (cq == 2'(q));

      // Keep the top two bits of every sample
      // Dropping the LSB halves the levels and keeps the code order
      for (genvar l = 0; l < LANES; l++) begin : g_lane
        assign tx[l] = smp_x[q][l][2:1];
        assign ty[l] = smp_y[q][l][2:1];
      end

      // Applied setup changes only on a clean commit
      // Other quadrants keep streaming while one is reconfigured
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          cfg_r[q] <= `HSC_RST_CFG;
          win_r[q] <= '0;
        end else if (hit) begin
          cfg_r[q] <= stage_r;
          win_r[q] <= swin_r;
        end
      end

      // Wideband stream goes straight to the lag correlator
      // Only valid is gated by the mode; data lanes follow the input anyway,
      // which saves a mux per lane but leaves consumers to watch valid
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          wb_valid[q] <= 1'b0;
          wb_x[q] <= '0;
          wb_y[q] <= '0;
        end else begin
          wb_valid[q] <= smp_valid[q] && !narrow;
          wb_x[q] <= tx;
          wb_y[q] <= ty;
        end
      end

      // Narrowband stream keeps full precision for the filter bank
      // The filter bank itself sits outside this block
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          fb_valid[q] <= 1'b0;
          fb_x[q] <= '0;
          fb_y[q] <= '0;
        end else begin
          fb_valid[q] <= smp_valid[q] && narrow;
          fb_x[q] <= smp_x[q];
          fb_y[q] <= smp_y[q];
        end
      end

      // Filter bank and oscillator settings follow the applied setup
      // They move only at a commit, which applies at once even in the middle of a stream
      assign fb_cfg[q] = cfg_r[q];
      assign fb_win[q] = win_r[q];

      // Auto and cross products from the same registered word
      // Only the wideband path feeds these sums; lane l of X pairs with Y
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          acc_r[q][0] <= '0;
          acc_r[q][1] <= '0;
          acc_r[q][2] <= '0;
        end else if (hit) begin
          // A new setup starts a fresh integration
          acc_r[q][0] <= '0;
          acc_r[q][1] <= '0;
          acc_r[q][2] <= '0;
        end else if (wb_valid[q]) begin
          acc_r[q][0] <= acc_r[q][0] + ACC_W'(lag0(wb_x[q], wb_x[q]));
          acc_r[q][1] <= acc_r[q][1] + ACC_W'(lag0(wb_y[q], wb_y[q]));
          acc_r[q][2] <= acc_r[q][2] + ACC_W'(lag0(wb_x[q], wb_y[q]));
        end
      end
    end
  endgenerate

  // ---------------------------------------------
  // Read path
  // ---------------------------------------------
  // Unmapped and write-only offsets read as zero; unaligned offsets at 0x40-0x5F and 0x80-0xBF alias their word
  // Reads have no side effects, so software may poll any offset
  wire [1:0] rq = reg_addr[3:2];
  wire rq_ok = 32'(rq) < QUADS;
  wire [1:0] aq = reg_addr[5:4];
  // Fourth word of each accumulator group is unused
  wire aq_ok = (32'(aq) < QUADS) && (reg_addr[3:2] != 2'h3);

  // Read mux, first match wins
  always_comb begin
    rd_val = 32'h0000_0000;
    if (reg_addr == `HSC_A_STAGE) begin
      rd_val = 32'(stage_r);
    end else if (win_sel) begin
      rd_val = 32'(swin_r[win_idx]);
    end else if (reg_addr == `HSC_A_COMMIT) begin
      rd_val = 32'(cmt_r);
    end else if (reg_addr == `HSC_A_STATUS) begin
      rd_val = 32'(sts_r);
    end else if (reg_addr == `HSC_A_ENABLE) begin
      rd_val = 32'(en_r);
    end else if ((reg_addr[7:4] == 4'h4) && rq_ok) begin
      rd_val = 32'(cfg_r[rq]);
    end else if ((reg_addr[7:4] == 4'h5) && rq_ok) begin
      rd_val = 32'(chans(cfg_r[rq]));
    end else if ((reg_addr[7:6] == 2'h2) && aq_ok) begin
      rd_val = 32'(acc_r[aq][reg_addr[3:2]]);
    end
  end

  // Data stand only in the cycle after the read strobe
  // Zero between reads, so a late sample by the master shows plainly
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rd_val : 32'h0000_0000;
    end
  end

endmodule // hsc_quad_front

// [verilog/hsc_map.svh]
// Offsets, field positions, reset values and rates of the correlator front end
`ifndef HSC_MAP_SVH
`define HSC_MAP_SVH

// ---------------------------------------------
// Register byte offsets
// ---------------------------------------------
`define HSC_A_STAGE 8'h00
`define HSC_A_WIN0 8'h04
`define HSC_A_COMMIT 8'h14
`define HSC_A_STATUS 8'h18
`define HSC_A_CLEAR 8'h1C
`define HSC_A_ENABLE 8'h20
`define HSC_A_QCFG0 8'h40
`define HSC_A_QCHAN0 8'h50
`define HSC_A_ACC0 8'h80

// ---------------------------------------------
// Fields, limits and reset values
// ---------------------------------------------
`define HSC_STAGE_W 11
`define HSC_WIN_W 16
`define HSC_ST_ERR 0
`define HSC_ST_APPLIED 1
`define HSC_ST_W 2
`define HSC_SUB_NUM 6'h20
`define HSC_SB_MAX 3'h5
`define HSC_AVG_MAX 3'h4
`define HSC_WIN_MAX 3'h4
`define HSC_NB_CHAN 13'h1E00
`define HSC_WB_CHAN 13'h0100
`define HSC_RST_CFG 11'h001
`define HSC_TUNE_STEP_HZ 30500
`define HSC_SMP_HZ 4000000000
`define HSC_CORR_HZ 125000000
`define HSC_DEMUX 32
`define HSC_CLK_HZ 25000000

`endif

// [verilog/hsc_pkg.sv]
// Types shared by the correlator front end
package hsc_pkg;

  // Per-quadrant mode and spectral setup
  typedef struct packed {
    logic narrow;          // 1: narrowband sub-band mode
    logic pol_full;        // 1: four polarization products
    logic [2:0] sb_code;   // Sub-bands per window = 32 >> code
    logic [2:0] avg_code;  // Channels averaged = 1 << code in narrowband mode
    logic [2:0] nwin;      // Windows in use, 1..4
  } hsc_cfg_type;

  // One spectral window placement
  typedef struct packed {
    logic [4:0] start;     // First sub-band
    logic [10:0] tune;     // Oscillator offset in tuning steps
  } hsc_win_type;

  // Commit outcome
  typedef enum logic [1:0] {
    HSC_IDLE,
    HSC_APPLY,
    HSC_REJECT
  } hsc_commit_type;

endpackage

// [verif/hsc_quad_front_chk.sv]
// Checker of quadrant routing, requantization and applied setup
`timescale 1ns/100ps
`include "hsc_map.svh"
module hsc_quad_front_chk #(
  parameter int QUADS = 4,
  parameter int LANES = 32
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [QUADS-1:0] smp_valid,
  input wire logic [QUADS-1:0][LANES-1:0][2:0] smp_x,
  input wire logic [QUADS-1:0] wb_valid,
  input wire logic [QUADS-1:0][LANES-1:0][1:0] wb_x,
  input wire logic [QUADS-1:0] fb_valid,
  input wire logic [QUADS-1:0][LANES-1:0][2:0] fb_x,
  input wire hsc_pkg::hsc_cfg_type [QUADS-1:0] fb_cfg,
  input wire hsc_pkg::hsc_win_type [QUADS-1:0][3:0] fb_win
);
  // ----------------
  // Helpers
  // ----------------
  // Lane-wise top two bits
  function automatic logic [LANES-1:0][1:0] top2(input logic [LANES-1:0][2:0] s);
    logic [LANES-1:0][1:0] r;
    for (int l = 0; l < LANES; l++) begin
      r[l] = s[l][2:1];
    end
    return r;
  endfunction
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Word arriving on a wideband quadrant
  sequence wide_in_s;
    smp_valid[0] && !fb_cfg[0].narrow;
  endsequence
  // ----------------
  // Assertions
  // ----------------
  wide_route_a: assert property (wide_in_s |=> wb_valid[0] && !fb_valid[0])
    else $error("wideband word not routed to correlator");
  narrow_route_a: assert property (smp_valid[1] && fb_cfg[1].narrow |=> fb_valid[1] && !wb_valid[1])
    else $error("narrowband word not routed to filter bank");
  no_stray_a: assert property (!smp_valid[0] |=> !wb_valid[0] && !fb_valid[0])
    else $error("output valid without input word");
  lsb_drop_a: assert property (wb_valid[0] |-> wb_x[0] == top2($past(smp_x[0])))
    else $error("wideband sample not cut to top bits");
  full_pass_a: assert property (fb_valid[0] |-> fb_x[0] == $past(smp_x[0]))
    else $error("filter bank sample altered");
  cfg_commit_a: assert property ($changed(fb_cfg[0]) |-> $past(reg_wr && reg_addr == `HSC_A_COMMIT))
    else $error("setup changed without commit");
  code_legal_a: assert property (fb_cfg[0].sb_code <= 3'h5 && fb_cfg[0].avg_code <= 3'h4)
    else $error("illegal sub-band or averaging code applied");
  win_count_a: assert property (fb_cfg[0].nwin >= 3'h1 && fb_cfg[0].nwin <= 3'h4)
    else $error("illegal window count applied");
  edge_fit_a: assert property (fb_cfg[0].narrow |->
    6'(fb_win[0][0].start) + (6'h20 >> fb_cfg[0].sb_code) <= 6'h20)
    else $error("window runs past band edge");
endmodule // hsc_quad_front_chk

bind hsc_quad_front hsc_quad_front_chk #(.QUADS(QUADS), .LANES(LANES)) u_hsc_quad_front_chk (
  .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr), .smp_valid(smp_valid),
  .smp_x(smp_x), .wb_valid(wb_valid), .wb_x(wb_x), .fb_valid(fb_valid), .fb_x(fb_x),
  .fb_cfg(fb_cfg), .fb_win(fb_win));

// [verif/hsc_dig_model.sv]
// Digitizer and fibre link model feeding all quadrants
`timescale 1ns/100ps
module hsc_dig_model (
  input wire logic clk,
  input wire logic run,
  output logic [3:0] smp_valid,
  output logic [3:0][31:0][2:0] smp_x,
  output logic [3:0][31:0][2:0] smp_y
);
  int seed = 32'h24FC; // Fixed seed, repeatable runs
  initial begin
    smp_valid = 4'h0;
    smp_x = '0;
    smp_y = '0;
  end
  // Random words with gaps; idle data inverts so nothing stale looks valid
  always @(posedge clk) begin
    smp_valid <= run ? 4'($random(seed)) : 4'h0;
    for (int q = 0; q < 4; q++) begin
      for (int l = 0; l < 32; l++) begin
        smp_x[q][l] <= run ? 3'($random(seed)) : ~smp_x[q][l];
        smp_y[q][l] <= run ? 3'($random(seed)) : ~smp_y[q][l];
      end
    end
  end
endmodule // hsc_dig_model

// [verif/hsc_quad_front_tb_top.sv]
// Self-checking bench for the quadrant front end
`timescale 1ns/100ps
`include "hsc_map.svh"
module hsc_quad_front_tb_top;
  // ----------------
  // Signals
  // ----------------
  logic clk = 1'b0;
  logic rst_b = 1'b0; // Held low ten cycles
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic run = 1'b0;
  logic [31:0] reg_rdata;
  logic [3:0] smp_valid, wb_valid, fb_valid;
  logic [3:0][31:0][2:0] smp_x, smp_y, fb_x, fb_y;
  logic [3:0][31:0][1:0] wb_x, wb_y;
  hsc_pkg::hsc_cfg_type [3:0] fb_cfg;
  hsc_pkg::hsc_win_type [3:0][3:0] fb_win;
  logic irq;
  int err_count = 0;
  int check_count = 0;
  int ax = 0, ay = 0, axy = 0; // Expected lag-zero sums, quadrant 0
  logic [39:0] rq[$], re; // Expected reads
  logic [192:0] sq[$], se; // Expected words: narrow flag, x, y
  logic [10:0] cur [4] = '{default: `HSC_RST_CFG};
  logic nb0 = 1'b0;
  logic rd_d = 1'b0;
  always #20 clk = ~clk;
  hsc_quad_front u_hsc_quad_front (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .smp_valid(smp_valid), .smp_x(smp_x), .smp_y(smp_y), .wb_valid(wb_valid), .wb_x(wb_x),
    .wb_y(wb_y), .fb_valid(fb_valid), .fb_x(fb_x), .fb_y(fb_y), .fb_cfg(fb_cfg),
    .fb_win(fb_win), .irq(irq));
  hsc_dig_model u_hsc_dig_model (.clk(clk), .run(run), .smp_valid(smp_valid), .smp_x(smp_x),
    .smp_y(smp_y));
  // ----------------
  // Helpers
  // ----------------
  function automatic int wt(input logic [2:0] c);
    return 2 * int'(c[2:1]) - 3;
  endfunction
  function automatic logic [63:0] top2(input logic [95:0] s);
    logic [63:0] r;
    for (int l = 0; l < 32; l++) begin
      r[2*l +: 2] = s[3*l+1 +: 2];
    end
    return r;
  endfunction
  function automatic logic [31:0] chan(input logic [10:0] s);
    if (s[10]) begin
      return 32'((`HSC_NB_CHAN >> (s[9] ? 2 : 1)) >> s[5:3]);
    end
    return 32'(`HSC_WB_CHAN >> (s[9] ? 2 : 1));
  endfunction
  task automatic check(input string nm, input logic [95:0] seen, input logic [95:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Gap cycle between strobes keeps drivers single-assigned
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rq.push_back({a, d});
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  // Stage, place windows, commit, then read outcome and applied setup
  task automatic try(input logic [1:0] q, input logic [10:0] st, input logic [15:0] w,
    input logic [1:0] ok);
    reg_write(`HSC_A_STAGE, 32'(st));
    for (int k = 0; k < 4; k++) begin
      reg_write(`HSC_A_WIN0 + 8'(4 * k), 32'(w));
    end
    reg_write(`HSC_A_COMMIT, 32'(q));
    reg_read(`HSC_A_COMMIT, 32'(ok));
    if (ok == 2'h1) begin
      cur[q] = st;
    end
    reg_read(`HSC_A_QCFG0 + 8'(4 * q), 32'(cur[q]));
    reg_read(`HSC_A_QCHAN0 + 8'(4 * q), chan(cur[q]));
    check("fb_cfg", 96'(fb_cfg[q]), 96'(cur[q]));
    if (ok == 2'h1) begin
      check("fb_win", 96'(fb_win[q]), 96'({4{w}}));
    end
  endtask
  task automatic stream(input int n);
    @(posedge clk);
    run <= 1'b1;
    repeat (n) @(posedge clk);
    run <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ----------------
  // Note inputs, compare outputs when they appear
  // ----------------
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d === 1'b1) begin
      re = rq.pop_front();
      check($sformatf("reg_rdata at %h", re[39:32]), 96'(reg_rdata), 96'(re[31:0]));
    end
    if (smp_valid[0] === 1'b1) begin
      sq.push_back({nb0, smp_x[0], smp_y[0]});
      for (int l = 0; l < 32 && !nb0; l++) begin
        ax += wt(smp_x[0][l]) * wt(smp_x[0][l]);
        ay += wt(smp_y[0][l]) * wt(smp_y[0][l]);
        axy += wt(smp_x[0][l]) * wt(smp_y[0][l]);
      end
    end
    if (wb_valid[0] === 1'b1 || fb_valid[0] === 1'b1) begin
      se = (sq.size() > 0) ? sq.pop_front() : '1;
      check("fb_valid", 96'(fb_valid[0]), 96'(se[192]));
      if (se[192]) begin
        check("fb_x", 96'(fb_x[0]), se[191:96]);
        check("fb_y", 96'(fb_y[0]), se[95:0]);
      end else begin
        check("wb_x", 96'(wb_x[0]), 96'(top2(se[191:96])));
        check("wb_y", 96'(wb_y[0]), 96'(top2(se[95:0])));
      end
    end
  end
  // Far longer than the sequence needs
  initial begin
    #800000;
    err_count++;
    end_of_test;
  end
  // ----------------
  // Main sequence
  // ----------------
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    reg_read(8'hFC, 32'h0);
    try(0, 11'h181, 16'h0, 2'h2);
    $display("test reset values done");
    stream(40);
    reg_read(`HSC_A_ACC0, 32'(ax));
    reg_read(`HSC_A_ACC0 + 8'h04, 32'(ay));
    reg_read(`HSC_A_ACC0 + 8'h08, 32'(axy));
    $display("test wideband stream done");
    reg_write(`HSC_A_CLEAR, 32'h3);
    reg_write(`HSC_A_ENABLE, 32'h1);
    try(0, 11'h029, 16'h0, 2'h2);
    try(0, 11'h000, 16'h0, 2'h2);
    try(0, 11'h005, 16'h0, 2'h2);
    try(0, 11'h401, 16'h0800, 2'h2);
    try(0, 11'h441, 16'h8001, 2'h2);
    repeat (3) @(posedge clk);
    check("irq", 96'(irq), 96'h1);
    reg_write(`HSC_A_CLEAR, 32'h3);
    repeat (3) @(posedge clk);
    check("irq", 96'(irq), 96'h0);
    $display("test rejected setups done");
    try(0, 11'h441, 16'h7801, 2'h1);
    try(0, 11'h201, 16'h0, 2'h1);
    for (int i = 0; i < 6; i++) begin
      try(0, {1'b1, i[0], 3'(i), 3'(i % 5), 3'(1 + i % 4)}, 16'h0, 2'h1);
    end
    try(1, 11'h401, 16'h0, 2'h1);
    $display("test legal setups done");
    nb0 = 1'b1;
    stream(30);
    check("pending words", 96'(sq.size()), 96'h0);
    $display("test narrowband stream done");
    end_of_test;
  end
endmodule // hsc_quad_front_tb_top
